// File: hdl/pss_pkg.sv
package pss_pkg;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_HZ       = 125_000_000;
  localparam int OSC_HZ       = 2_100_000;
  localparam logic [5:0] OSC_DIV = 6'(CLK_HZ / OSC_HZ);
  localparam int RELEASE_MS   = 12;
  localparam logic [14:0] RELEASE_TICKS = 15'((RELEASE_MS * OSC_HZ + 999) / 1000);
  localparam int ERR_US       = 100;
  localparam logic [14:0] ERR_TICKS = 15'((ERR_US * OSC_HZ + 999_999) / 1_000_000);
  localparam logic [14:0] WD_TICKS   = 15'd2100;
  localparam logic [14:0] STEP_TICKS = 15'd21;
  localparam logic [14:0] DIAG_TICKS = 15'd21;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [5:0] ADDR_IDENT  = 6'h00;
  localparam logic [5:0] ADDR_PIN_LEVEL_MONITOR = 6'h02;
  localparam logic [5:0] ADDR_CONFIG = 6'h10;
  localparam logic [5:0] ADDR_KEY    = 6'h11;
  localparam int CFG_ERR_RST  = 4;
  localparam int CFG_WD_SRC   = 3;
  localparam int CFG_LOW_RAIL = 2;
  localparam int CFG_WD_ADV   = 1;
  localparam int CFG_EARLY    = 0;
  localparam logic [4:0] CFG_RESET = 5'h00;
  localparam int PM_WD_DIS    = 2;
  localparam int PM_ERR2      = 1;
  localparam int PM_ERR1      = 0;
  localparam logic [7:0] LFSR_SEED = 8'h01;
  // Arbitrary neutral identification value
  localparam logic [7:0] IDENT_CODE = 8'h5A;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [3:0] {
    PSS_PDOWN, PSS_STBY, PSS_DIAG, PSS_PU, PSS_NORM,
    PSS_RST1, PSS_PD1, PSS_RST2, PSS_PD2, PSS_COOL
  } pss_state_type;

  typedef struct packed {
    logic       en_a;
    logic       en_b;
    logic       sre;
    logic       supply_ok;
    logic       over_temp;
    logic       below_rel;
    logic       rails_up;
    logic       main_low;
    logic       core_low;
    logic       io_low;
    logic       vin_full;
    logic       vin_part;
    logic       wd_dis;
    logic       wd_clr;
    logic [1:0] err;
  } pss_sense_type;

  typedef struct packed {
    logic       wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } pss_req_type;

endpackage

// File: hdl/pss_sequencer.sv
`timescale 1ns/1ps
module pss_sequencer #(
  parameter logic [14:0] RELEASE_TICKS = pss_pkg::RELEASE_TICKS,
  parameter logic [14:0] ERR_TICKS     = pss_pkg::ERR_TICKS,
  parameter logic [14:0] WD_TICKS      = pss_pkg::WD_TICKS,
  parameter logic [14:0] STEP_TICKS    = pss_pkg::STEP_TICKS,
  parameter logic [14:0] DIAG_TICKS    = pss_pkg::DIAG_TICKS
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire pss_pkg::pss_sense_type sense_i,
  input  wire logic                   req_valid_i,
  input  wire pss_pkg::pss_req_type   req_i,
  input  wire logic                   wd_serial_clear_i,
  output logic [7:0]                  rdata_o,
  output logic                        rdata_valid_o,
  output logic                        reset_out_n_o,
  output logic                        reset_out_n_oe_o,
  output logic                        interrupt_out_o,
  output logic                        standby_reg_on_o,
  output logic [3:0]                  rails_on_o,
  output logic                        pre_switcher_on_o,
  output logic                        wd_running_o,
  output logic                        wd_advanced_o,
  output pss_pkg::pss_state_type      state_o
);

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  // A change counts once stages two and three agree
  logic [15:0] s1_r, s2_r, s3_r, flt_r;
  wire  [15:0] flt_nxt = (s2_r & s3_r) | (flt_r & (s2_r | s3_r));
  pss_pkg::pss_sense_type pin;
  assign pin = flt_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_r  <= 16'h0000;
      s2_r  <= 16'h0000;
      s3_r  <= 16'h0000;
      flt_r <= 16'h0000;
    end else begin
      s1_r  <= sense_i;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      flt_r <= flt_nxt;
    end
  end

  // ***************************************************************
  // Oscillator tick
  // ***************************************************************
  logic [5:0] div_r;
  wire        osc_tick = (div_r == pss_pkg::OSC_DIV - 6'h01);
  wire  [5:0] div_nxt  = osc_tick ? 6'h00 : div_r + 6'h01;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) div_r <= 6'h00;
    else div_r <= div_nxt;
  end

  // ***************************************************************
  // Conditions
  // ***************************************************************
  pss_pkg::pss_state_type state_r, state_nxt;
  logic [14:0] tmr_r, stp_r, wd_cnt_r, err_cnt_r;
  logic [4:0]  cfg_r;
  logic [3:0]  rails_r;
  logic        wd_run_r, err_smp_r, clr_prev_r, int_r;

  wire en_any   = pin.en_a | pin.en_b;
  wire lv_en    = pin.vin_part;
  wire shutdown = !en_any | (pin.main_low & lv_en);
  wire in_pd    = (state_r == pss_pkg::PSS_PD1) | (state_r == pss_pkg::PSS_PD2);
  wire stp_tick = osc_tick & (stp_r == STEP_TICKS - 15'h0001);

  // Watchdog, error and rail faults
  wire wd_act   = (state_r == pss_pkg::PSS_NORM) & wd_run_r;
  wire pin_clr  = pin.wd_clr & !clr_prev_r;
  wire clr_evt  = cfg_r[pss_pkg::CFG_WD_SRC] ? wd_serial_clear_i : pin_clr;
  wire wd_exp   = wd_act & (wd_cnt_r == WD_TICKS);
  wire early    = wd_act & clr_evt & cfg_r[pss_pkg::CFG_EARLY]
                  & (wd_cnt_r < (WD_TICKS >> 1));
  wire err_rst  = cfg_r[pss_pkg::CFG_ERR_RST] & err_smp_r;
  wire rail_rst = cfg_r[pss_pkg::CFG_LOW_RAIL] & lv_en
                  & (pin.core_low | pin.io_low);
  wire fault    = wd_exp | early | err_rst | rail_rst;

  // ***************************************************************
  // State walk
  // ***************************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pss_pkg::PSS_PDOWN: begin
        if (en_any && (!pin.sre || pin.supply_ok)) state_nxt = pss_pkg::PSS_DIAG;
        else if (!en_any && pin.sre) state_nxt = pss_pkg::PSS_STBY;
      end
      pss_pkg::PSS_STBY: begin
        if (en_any && !pin.supply_ok) state_nxt = pss_pkg::PSS_PDOWN;
        else if (en_any) state_nxt = pss_pkg::PSS_DIAG;
        else if (!pin.sre) state_nxt = pss_pkg::PSS_PDOWN;
      end
      pss_pkg::PSS_DIAG: begin
        if (pin.over_temp) state_nxt = pss_pkg::PSS_RST2;
        else if (tmr_r >= DIAG_TICKS) state_nxt = pss_pkg::PSS_PU;
      end
      pss_pkg::PSS_PU: begin
        if (pin.over_temp) state_nxt = pss_pkg::PSS_RST2;
        else if (shutdown) state_nxt = pss_pkg::PSS_RST1;
        // Strictly past the count, so a partial first tick never shortens the delay
        else if (pin.rails_up && tmr_r > RELEASE_TICKS) state_nxt = pss_pkg::PSS_NORM;
      end
      pss_pkg::PSS_NORM: begin
        if (pin.over_temp) state_nxt = pss_pkg::PSS_RST2;
        else if (shutdown) state_nxt = pss_pkg::PSS_RST1;
        else if (fault) state_nxt = pss_pkg::PSS_PU;
      end
      pss_pkg::PSS_RST1: state_nxt = pss_pkg::PSS_PD1;
      pss_pkg::PSS_PD1: begin
        if (rails_r == 4'h0 && pin.over_temp) state_nxt = pss_pkg::PSS_COOL;
        else if (rails_r == 4'h0 && pin.below_rel) state_nxt = pss_pkg::PSS_STBY;
      end
      pss_pkg::PSS_RST2: state_nxt = pss_pkg::PSS_PD2;
      pss_pkg::PSS_PD2: begin
        if (rails_r == 4'h0) state_nxt = pss_pkg::PSS_COOL;
      end
      pss_pkg::PSS_COOL: begin
        if (pin.below_rel) state_nxt = pss_pkg::PSS_STBY;
      end
      default: state_nxt = pss_pkg::PSS_PDOWN;
    endcase
  end

  // Timer restarts on each state change and, in power-up, while a rail is still down
  wire restart = (state_nxt != state_r) | ((state_r == pss_pkg::PSS_PU) & !pin.rails_up);
  wire [14:0] tmr_nxt = restart ? 15'h0000 :
                        (osc_tick && tmr_r != 15'h7FFF) ? tmr_r + 15'h0001 : tmr_r;
  wire stepping = (state_r == pss_pkg::PSS_PU) | in_pd;
  wire [14:0] stp_nxt = (!stepping || stp_tick) ? 15'h0000 :
                        osc_tick ? stp_r + 15'h0001 : stp_r;

  // Rails on in order, off in the reverse order
  logic [3:0] rails_nxt;
  always_comb begin
    rails_nxt = rails_r;
    if (state_r == pss_pkg::PSS_PU && stp_tick) rails_nxt = {rails_r[2:0], 1'b1};
    else if (in_pd && stp_tick) rails_nxt = rails_r >> 1;
    else if (!stepping && state_r != pss_pkg::PSS_NORM && state_r != pss_pkg::PSS_RST1
             && state_r != pss_pkg::PSS_RST2) rails_nxt = 4'h0;
  end

  // Reset held low everywhere but normal operation
  wire rst_nxt = (state_nxt != pss_pkg::PSS_NORM);
  wire sby_nxt = (state_nxt != pss_pkg::PSS_PDOWN);
  wire int_nxt = (state_r == pss_pkg::PSS_PU && pin.rails_up) ? 1'b1 :
                 (state_r == pss_pkg::PSS_STBY || state_r == pss_pkg::PSS_PDOWN) ? 1'b0 : int_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= pss_pkg::PSS_PDOWN;
      tmr_r   <= 15'h0000;
      stp_r   <= 15'h0000;
      rails_r <= 4'h0;
      int_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tmr_r   <= tmr_nxt;
      stp_r   <= stp_nxt;
      rails_r <= rails_nxt;
      int_r   <= int_nxt;
    end
  end

  // ***************************************************************
  // Watchdog and error monitor
  // ***************************************************************
  wire stby     = (state_r == pss_pkg::PSS_STBY);
  wire run_nxt  = (state_r == pss_pkg::PSS_PU) ? !pin.wd_dis : (stby ? 1'b0 : wd_run_r);
  wire [14:0] wd_nxt = (!wd_act || clr_evt) ? 15'h0000 :
                       osc_tick ? wd_cnt_r + 15'h0001 : wd_cnt_r;
  // Sampling starts only once reset has been released
  wire in_norm  = (state_r == pss_pkg::PSS_NORM);
  wire err_hit  = osc_tick & (err_cnt_r == ERR_TICKS - 15'h0001);
  wire [14:0] ecnt_nxt = (!in_norm || err_hit) ? 15'h0000 :
                         osc_tick ? err_cnt_r + 15'h0001 : err_cnt_r;
  wire esmp_nxt = !in_norm ? 1'b0 : (err_hit ? |pin.err : err_smp_r);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wd_run_r   <= 1'b0;
      wd_cnt_r   <= 15'h0000;
      err_cnt_r  <= 15'h0000;
      err_smp_r  <= 1'b0;
      clr_prev_r <= 1'b0;
    end else begin
      wd_run_r   <= run_nxt;
      wd_cnt_r   <= wd_nxt;
      err_cnt_r  <= ecnt_nxt;
      err_smp_r  <= esmp_nxt;
      clr_prev_r <= pin.wd_clr;
    end
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  logic [7:0] lfsr_r, key_r, rdata_r;
  logic       unlock_r, rvalid_r;
  wire rd      = req_valid_i & !req_i.wr;
  wire wr      = req_valid_i & req_i.wr;
  wire key_rd  = rd & (req_i.addr == pss_pkg::ADDR_KEY);
  wire key_ok  = wr & (req_i.addr == pss_pkg::ADDR_KEY) & (req_i.wdata == key_r);
  wire cfg_wr  = wr & (req_i.addr == pss_pkg::ADDR_CONFIG);
  wire [7:0] lfsr_nxt = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
  wire [7:0] pin_level_monitor   = {5'h00, pin.wd_dis, pin.err[1], pin.err[0]};
  logic [7:0] rmux;
  always_comb begin
    if (req_i.addr == pss_pkg::ADDR_IDENT) rmux = pss_pkg::IDENT_CODE;
    else if (req_i.addr == pss_pkg::ADDR_PIN_LEVEL_MONITOR) rmux = pin_level_monitor;
    else if (req_i.addr == pss_pkg::ADDR_CONFIG) rmux = {3'h0, cfg_r};
    else if (req_i.addr == pss_pkg::ADDR_KEY) rmux = lfsr_r;
    else rmux = 8'h00;
  end
  // Only power down clears the configuration, never the reset output
  wire [4:0] cfg_nxt = (state_r == pss_pkg::PSS_PDOWN) ? pss_pkg::CFG_RESET :
                       (cfg_wr && unlock_r) ? req_i.wdata[4:0] : cfg_r;
  wire unl_nxt = key_ok ? 1'b1 : ((cfg_wr || stby) ? 1'b0 : unlock_r);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lfsr_r   <= pss_pkg::LFSR_SEED;
      key_r    <= 8'h00;
      cfg_r    <= pss_pkg::CFG_RESET;
      unlock_r <= 1'b0;
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      lfsr_r   <= lfsr_nxt;
      key_r    <= key_rd ? lfsr_r : key_r;
      cfg_r    <= cfg_nxt;
      unlock_r <= unl_nxt;
      rdata_r  <= rd ? rmux : rdata_r;
      rvalid_r <= rd;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  logic rst_oe_r, sby_r, pre_r, wdrun_r, adv_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_oe_r <= 1'b1;
      sby_r    <= 1'b0;
      pre_r    <= 1'b0;
      wdrun_r  <= 1'b0;
      adv_r    <= 1'b0;
    end else begin
      rst_oe_r <= rst_nxt;
      sby_r    <= sby_nxt;
      pre_r    <= rails_nxt[0] & pin.vin_full;
      wdrun_r  <= wd_act;
      adv_r    <= cfg_r[pss_pkg::CFG_WD_ADV] & cfg_r[pss_pkg::CFG_WD_SRC];
    end
  end

  // Open drain: the pin is only ever pulled low
  assign reset_out_n_o     = 1'b0;
  assign reset_out_n_oe_o  = rst_oe_r;
  assign interrupt_out_o   = int_r;
  assign standby_reg_on_o  = sby_r;
  assign rails_on_o        = rails_r;
  assign pre_switcher_on_o = pre_r;
  assign wd_running_o      = wdrun_r;
  assign wd_advanced_o     = adv_r;
  assign rdata_o           = rdata_r;
  assign rdata_valid_o     = rvalid_r;
  assign state_o           = state_r;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  reset_hold_a: assert property ((state_r != pss_pkg::PSS_NORM) |-> reset_out_n_oe_o)
    else $error("Reset released outside normal");
  release_wait_a: assert property (
    (state_r == pss_pkg::PSS_PU && state_nxt == pss_pkg::PSS_NORM) |-> tmr_r > RELEASE_TICKS)
    else $error("Reset released early");
  hot_reset_a: assert property (
    (state_r == pss_pkg::PSS_NORM && pin.over_temp) |=> state_r == pss_pkg::PSS_RST2 ##1
    state_r == pss_pkg::PSS_PD2)
    else $error("Over-temperature not handled");
  enable_drop_a: assert property (
    (state_r == pss_pkg::PSS_NORM && !en_any && !pin.over_temp) |=>
    state_r == pss_pkg::PSS_RST1 && reset_out_n_oe_o)
    else $error("Enable drop missed");
  pd_return_a: assert property (
    (state_r == pss_pkg::PSS_PD1 && rails_r == 4'h0 && !pin.over_temp && pin.below_rel)
    |=> state_r == pss_pkg::PSS_STBY)
    else $error("No return to stand-by");
  pd2_cool_a: assert property (
    (state_r == pss_pkg::PSS_PD2 && rails_r == 4'h0) |=> state_r == pss_pkg::PSS_COOL)
    else $error("Cool down not entered");
  cool_hold_a: assert property (
    (state_r == pss_pkg::PSS_COOL && !pin.below_rel) |=> state_r == pss_pkg::PSS_COOL)
    else $error("Cool down left while hot");
  cfg_lock_a: assert property ((cfg_wr && !unlock_r && state_r != pss_pkg::PSS_PDOWN)
    |=> $stable(cfg_r))
    else $error("Locked configuration written");
  int_release_a: assert property ($rose(interrupt_out_o) |->
    $past(state_r) == pss_pkg::PSS_PU && $past(pin.rails_up))
    else $error("Interrupt released before rails up");
  low_supply_a: assert property (
    (state_r == pss_pkg::PSS_STBY && en_any && !pin.supply_ok) |=>
    state_r == pss_pkg::PSS_PDOWN && !standby_reg_on_o)
    else $error("Power down not entered");

endmodule

// File: bench/pss_host.sv
`timescale 1ns/1ps
module pss_host #(
  parameter int PERIOD = 1500
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  output logic      wd_clr_o,
  output logic      serial_clr_o
);
  // ***************************************************************
  // Watchdog refresh
  // ***************************************************************
  int cnt_r;
  // Period sits past the closed window yet well inside expiry
  always_ff @(negedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 0;
      wd_clr_o <= 1'b0;
      serial_clr_o <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
      // Pin pulse is long enough to pass the input filter
      wd_clr_o <= (cnt_r < 8);
      serial_clr_o <= (cnt_r == 0);
    end
  end
endmodule

// File: bench/power_state_sequencer_test.sv
`timescale 1ns/1ps
module power_state_sequencer_test;
  // ***************************************************************
  // Stimulus and wiring
  // ***************************************************************
  logic                   clk_i = 1'b0;
  logic                   rst_n_i = 1'b0;
  pss_pkg::pss_sense_type sense;
  pss_pkg::pss_sense_type sense_w;
  logic                   req_valid_i;
  pss_pkg::pss_req_type   req_i;
  logic                   wd_clr_w;
  logic                   serial_clr_w;
  logic [7:0]             rdata_o;
  logic                   rdata_valid_o;
  logic                   reset_out_n_o;
  logic                   reset_out_n_oe_o;
  logic                   interrupt_out_o;
  logic                   standby_reg_on_o;
  logic [3:0]             rails_on_o;
  logic                   pre_switcher_on_o;
  logic                   wd_running_o;
  logic                   wd_advanced_o;
  pss_pkg::pss_state_type state_o;
  int                     n_errors = 0;
  int                     total_checks = 0;
  int                     cyc = 0;
  logic                   wd_feed = 1'b1;

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  always_comb begin
    sense_w = sense;
    sense_w.wd_clr = wd_clr_w;
  end

  pss_sequencer #(
    .RELEASE_TICKS(15'h0014), .ERR_TICKS(15'h0004), .WD_TICKS(15'h0028),
    .STEP_TICKS(15'h0002), .DIAG_TICKS(15'h0002)
  ) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .sense_i(sense_w), .req_valid_i(req_valid_i),
    .req_i(req_i), .wd_serial_clear_i(serial_clr_w & wd_feed), .rdata_o(rdata_o),
    .rdata_valid_o(rdata_valid_o), .reset_out_n_o(reset_out_n_o),
    .reset_out_n_oe_o(reset_out_n_oe_o), .interrupt_out_o(interrupt_out_o),
    .standby_reg_on_o(standby_reg_on_o), .rails_on_o(rails_on_o),
    .pre_switcher_on_o(pre_switcher_on_o), .wd_running_o(wd_running_o),
    .wd_advanced_o(wd_advanced_o), .state_o(state_o)
  );

  pss_host host (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wd_clr_o(wd_clr_w), .serial_clr_o(serial_clr_w)
  );

  // ***************************************************************
  // Tasks
  // ***************************************************************
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req_valid_i = 1'b1;
    req_i = '{wr: 1'b1, addr: a, wdata: d};
    @(negedge clk_i);
    req_valid_i = 1'b0;
  endtask

  // Read data is looked at in the one cycle that it is flagged valid
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk_i);
    req_valid_i = 1'b1;
    req_i = '{wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clk_i);
    req_valid_i = 1'b0;
    chk({7'h00, rdata_valid_o}, 8'h01);
    d = rdata_o;
  endtask

  task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  task automatic unlock_wr(input logic [7:0] d);
    logic [7:0] k;
    rd(pss_pkg::ADDR_KEY, k);
    wr(pss_pkg::ADDR_KEY, k);
    wr(pss_pkg::ADDR_CONFIG, d);
    rdc(pss_pkg::ADDR_CONFIG, d);
  endtask

  task automatic wait_st(input pss_pkg::pss_state_type s, input int lim);
    int n;
    n = 0;
    while (state_o !== s && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    chk({4'h0, state_o}, {4'h0, s});
  endtask

  // Release must lag rails-up by at least 20 ticks of 59 clocks
  task automatic power_up();
    int n;
    sense.en_a = 1'b1;
    wait_st(pss_pkg::PSS_PU, 400);
    n = 0;
    while (reset_out_n_oe_o === 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    chk({7'h00, (n >= 1180 && n < 2200)}, 8'h01);
    wait_st(pss_pkg::PSS_NORM, 10);
    chk({3'h0, interrupt_out_o, rails_on_o}, 8'h1F);
  endtask

  // ***************************************************************
  // Sequence
  // ***************************************************************
  initial begin
    sense = '0;
    req_valid_i = 1'b0;
    req_i = '0;
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    rdc(pss_pkg::ADDR_IDENT, pss_pkg::IDENT_CODE);
    rdc(pss_pkg::ADDR_CONFIG, 8'h00);
    rdc(6'h05, 8'h00);
    sense.sre = 1'b1;
    sense.supply_ok = 1'b1;
    sense.below_rel = 1'b1;
    sense.vin_full = 1'b1;
    sense.vin_part = 1'b1;
    sense.rails_up = 1'b1;
    wait_st(pss_pkg::PSS_STBY, 50);
    chk({6'h00, reset_out_n_oe_o, standby_reg_on_o}, 8'h03);
    chk({4'h0, rails_on_o}, 8'h00);
    wr(pss_pkg::ADDR_CONFIG, 8'h1F);
    rdc(pss_pkg::ADDR_CONFIG, 8'h00);
    power_up();
    @(negedge clk_i);
    chk({6'h00, wd_running_o, pre_switcher_on_o}, 8'h03);
    unlock_wr(8'h12);
    chk({7'h00, wd_advanced_o}, 8'h00);
    unlock_wr(8'h1A);
    chk({7'h00, wd_advanced_o}, 8'h01);
    sense.vin_full = 1'b0;
    sense.vin_part = 1'b0;
    sense.main_low = 1'b1;
    repeat (200) @(negedge clk_i);
    chk({3'h0, pre_switcher_on_o, state_o}, {4'h0, pss_pkg::PSS_NORM});
    sense.main_low = 1'b0;
    sense.vin_full = 1'b1;
    sense.vin_part = 1'b1;
    sense.wd_dis = 1'b1;
    sense.err = 2'b01;
    repeat (8) @(negedge clk_i);
    rdc(pss_pkg::ADDR_PIN_LEVEL_MONITOR, 8'h05);
    wait_st(pss_pkg::PSS_PU, 400);
    chk({7'h00, reset_out_n_oe_o}, 8'h01);
    rdc(pss_pkg::ADDR_CONFIG, 8'h1A);
    sense.err = 2'b00;
    power_up();
    chk({7'h00, wd_running_o}, 8'h00);
    sense.over_temp = 1'b1;
    sense.below_rel = 1'b0;
    repeat (8) @(negedge clk_i);
    chk({7'h00, reset_out_n_oe_o}, 8'h01);
    wait_st(pss_pkg::PSS_COOL, 800);
    chk({4'h0, rails_on_o}, 8'h00);
    sense.over_temp = 1'b0;
    sense.below_rel = 1'b1;
    wait_st(pss_pkg::PSS_STBY, 50);
    sense.wd_dis = 1'b0;
    power_up();
    @(negedge clk_i);
    chk({7'h00, wd_running_o}, 8'h01);
    // Serial refresh withheld: the watchdog must expire and restart power-up
    wd_feed = 1'b0;
    wait_st(pss_pkg::PSS_PU, 2600);
    chk({7'h00, reset_out_n_oe_o}, 8'h01);
    wd_feed = 1'b1;
    power_up();
    unlock_wr(8'h1E);
    sense.core_low = 1'b1;
    wait_st(pss_pkg::PSS_PU, 50);
    sense.core_low = 1'b0;
    power_up();
    sense.en_a = 1'b0;
    repeat (7) @(negedge clk_i);
    chk({7'h00, reset_out_n_oe_o}, 8'h01);
    wait_st(pss_pkg::PSS_STBY, 800);
    chk({4'h0, rails_on_o}, 8'h00);
    sense.supply_ok = 1'b0;
    sense.en_b = 1'b1;
    wait_st(pss_pkg::PSS_PDOWN, 50);
    chk({7'h00, standby_reg_on_o}, 8'h00);
    rdc(pss_pkg::ADDR_CONFIG, 8'h00);
    sense.en_b = 1'b0;
    sense.supply_ok = 1'b1;
    wait_st(pss_pkg::PSS_STBY, 50);
    sense.sre = 1'b0;
    wait_st(pss_pkg::PSS_PDOWN, 50);
    print_verdict();
  end
endmodule
